// ### design/mmd_decoder.sv
`timescale 1ns/1ns
`default_nettype none

// Behaviour
// - 128 pages of 64K via 23 lines
// - Page register read/write at 001Eh
// - Reset clears page register
// - ROM decodes in program space only
// - Boot low at reset starts FF80h
// - Dual RAM: two accesses per cycle
// - Low dual RAM data, program when overlay
// - High dual RAM program, data when set
// - Single RAM pages 2/3, parallel blocks
// - Secure: non-ROM code reads ROM FFFFh
// - Secure: emulation off, boundary scan kept
// - RAM/ROM secure: boot bit reset zero
// - RAM/ROM secure: host reads 4000h-5FFFh
// - ROM-only: host free, boot follows pin
// - Vector slots four words, PC loaded
// - Vectors at page of pointer field
// - Reset sets pointer all ones
// - Mode register layout, pointer reset 1FF
// - Overlay never maps data page 0
// - Off-chip data addresses go external
// - Boot bit one hides ROM
module mmd_decoder
   import mmd_pkg::*;
(
   input wire logic MCLK_IN,
   input wire logic SRST_IN,
   input wire logic BOOT_PIN_IN,
   input wire mmd_sec_e SEC_MODE_IN,
   input wire logic [15:0] REG_ADDR_IN,
   input wire logic [15:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [15:0] REG_RDATA_OUT,
   input wire logic [15:0] PADDR_IN,
   input wire logic FETCH_FROM_ROM_IN,
   input wire logic [15:0] DADDR_A_IN,
   input wire logic [15:0] DADDR_B_IN,
   input wire logic DWR_B_IN,
   input wire logic [4:0] VEC_NUM_IN,
   input wire logic VEC_TAKE_IN,
   input wire logic [15:0] HOST_ADDR_IN,
   input wire logic HOST_RD_IN,
   output mmd_dec_s PDEC_OUT,
   output logic [22:0] PADDR_EXT_OUT,
   output mmd_dec_s DDEC_A_OUT,
   output mmd_dec_s DDEC_B_OUT,
   output logic DUAL_CONFLICT_OUT,
   output logic ROM_READ_LOCK_OUT,
   output logic [15:0] LOCKED_DATA_OUT,
   output logic [15:0] PC_LOAD_OUT,
   output logic PC_LOAD_VALID_OUT,
   output logic EMU_ENABLE_OUT,
   output logic BSCAN_ENABLE_OUT,
   output logic HOST_RD_OK_OUT,
   output logic [6:0] MODE_BITS_OUT
);

   logic [6:0] page_q;
   logic [8:0] vptr_q;
   logic [6:0] mbits_q;
   logic boot_s1_q;
   logic boot_s2_q;
   logic rst_seen_q;
   logic [15:0] mode_word;
   logic sec_on;
   logic [22:0] pext;
   mmd_dec_s pdec;
   mmd_dec_s ddec_a;
   mmd_dec_s ddec_b;

   // Two-stage synchroniser for the boot mode pin
   always_ff @(posedge MCLK_IN) begin
      boot_s1_q <= BOOT_PIN_IN;
      boot_s2_q <= boot_s1_q;
   end

   assign sec_on = (SEC_MODE_IN != MMD_SEC_NONE);
   assign mode_word = {vptr_q, mbits_q};

   // Page register: reset clears, software writes
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         page_q <= PAGE_RESET;
      end else if (REG_WR_IN && REG_ADDR_IN == PAGE_REG_ADDR) begin
         page_q <= REG_WDATA_IN[6:0];
      end
   end

   // Vector pointer field of the mode register
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         vptr_q <= VEC_PTR_RESET;
      end else if (REG_WR_IN && REG_ADDR_IN == MODE_REG_ADDR) begin
         vptr_q <= REG_WDATA_IN[15:VEC_PTR_LSB];
      end
   end

   // Low mode bits; boot bit is captured on the cycle after reset release
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         mbits_q <= 7'h00;
         rst_seen_q <= 1'b1;
      end else begin
         rst_seen_q <= 1'b0;
         if (REG_WR_IN && REG_ADDR_IN == MODE_REG_ADDR) begin
            mbits_q <= REG_WDATA_IN[6:0];
         end else if (rst_seen_q) begin
            mbits_q[BOOT_BIT] <= (SEC_MODE_IN == MMD_SEC_RAMROM) ? 1'b0 : boot_s2_q;
         end
      end
   end

   // Register read port, data one cycle after the strobe
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         REG_RDATA_OUT <= 16'h0000;
      end else if (REG_RD_IN && REG_ADDR_IN == PAGE_REG_ADDR) begin
         REG_RDATA_OUT <= {9'h000, page_q};
      end else if (REG_RD_IN && REG_ADDR_IN == MODE_REG_ADDR) begin
         REG_RDATA_OUT <= mode_word;
      end else begin
         REG_RDATA_OUT <= 16'h0000;
      end
   end

   // Extended program address: page above in-page offset
   assign pext = {page_q, PADDR_IN};

   // Program space decode
   always_comb begin
      pdec.tgt = MMD_TGT_EXT;
      pdec.blk = pext[15:13];
      if (pext[22:16] == PAGE_DUAL_ACCESS_RAM_HI && pext[15]) begin
         pdec.tgt = MMD_TGT_DUAL_ACCESS_RAM;
      end else if ((pext[22:16] == PAGE_SINGLE_ACCESS_RAM_A || pext[22:16] == PAGE_SINGLE_ACCESS_RAM_B) && pext[15]) begin
         pdec.tgt = MMD_TGT_SINGLE_ACCESS_RAM;
         pdec.blk = {pext[16], pext[14:13]};
      end else if (pext[15:0] >= ROM_BASE && !mbits_q[BOOT_BIT]) begin
         pdec.tgt = MMD_TGT_ROM;
         pdec.blk = 3'h0;
      end else if (mbits_q[RAM_OVERLAY_BIT_BIT] && !pext[15] && pext[15:0] > DATA_PAGE0_TOP) begin
         pdec.tgt = MMD_TGT_DUAL_ACCESS_RAM;
      end
   end

   // Data space decode, ROM never reachable here
   function automatic mmd_dec_s dec_data(input logic [15:0] a, input logic ram_to_data_bit);
      mmd_dec_s r;
      r.tgt = MMD_TGT_EXT;
      r.blk = a[15:13];
      if (a <= DATA_PAGE0_TOP) begin
         r.tgt = MMD_TGT_MMR;
      end else if (a <= DUAL_ACCESS_RAM_LO_TOP) begin
         r.tgt = MMD_TGT_DUAL_ACCESS_RAM;
      end else if (ram_to_data_bit) begin
         r.tgt = MMD_TGT_DUAL_ACCESS_RAM;
      end
      return r;
   endfunction : dec_data

   assign ddec_a = dec_data(DADDR_A_IN, mbits_q[RDATA_BIT]);
   assign ddec_b = dec_data(DADDR_B_IN, mbits_q[RDATA_BIT]);

   // Registered decode results
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         PDEC_OUT <= '{MMD_TGT_EXT, 3'h0};
         DDEC_A_OUT <= '{MMD_TGT_EXT, 3'h0};
         DDEC_B_OUT <= '{MMD_TGT_EXT, 3'h0};
         PADDR_EXT_OUT <= 23'h000000;
         DUAL_CONFLICT_OUT <= 1'b0;
      end else begin
         PDEC_OUT <= pdec;
         DDEC_A_OUT <= ddec_a;
         DDEC_B_OUT <= ddec_b;
         PADDR_EXT_OUT <= pext;
         // Dual RAM takes two reads or read plus write, so only a third access to one block clashes
         // Single RAM blocks take one access each, so program and data must use distinct blocks
         DUAL_CONFLICT_OUT <= (pdec.tgt == MMD_TGT_SINGLE_ACCESS_RAM && ddec_a.tgt == MMD_TGT_SINGLE_ACCESS_RAM
                               && pdec.blk == ddec_a.blk)
                              || (pdec.tgt == MMD_TGT_DUAL_ACCESS_RAM && ddec_a.tgt == MMD_TGT_DUAL_ACCESS_RAM
                                  && ddec_b.tgt == MMD_TGT_DUAL_ACCESS_RAM && pdec.blk == ddec_a.blk
                                  && pdec.blk == ddec_b.blk);
      end
   end

   // Security: ROM data read lockout, emulation gate, host read window
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         ROM_READ_LOCK_OUT <= 1'b0;
         LOCKED_DATA_OUT <= 16'h0000;
         EMU_ENABLE_OUT <= 1'b0;
         BSCAN_ENABLE_OUT <= 1'b1;
         HOST_RD_OK_OUT <= 1'b0;
      end else begin
         ROM_READ_LOCK_OUT <= sec_on && !FETCH_FROM_ROM_IN && pdec.tgt == MMD_TGT_ROM;
         LOCKED_DATA_OUT <= ROM_LOCKED_DATA;
         EMU_ENABLE_OUT <= !sec_on;
         BSCAN_ENABLE_OUT <= 1'b1;
         if (SEC_MODE_IN == MMD_SEC_RAMROM) begin
            HOST_RD_OK_OUT <= HOST_RD_IN && HOST_ADDR_IN >= HOST_RD_LO && HOST_ADDR_IN <= HOST_RD_HI;
         end else begin
            HOST_RD_OK_OUT <= HOST_RD_IN;
         end
      end
   end

   // Vector fetch: reset goes to FF80h, others to pointer page plus 4-word slot
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         PC_LOAD_OUT <= BOOT_VECTOR;
         PC_LOAD_VALID_OUT <= 1'b1;
      end else if (VEC_TAKE_IN) begin
         PC_LOAD_OUT <= {vptr_q, VEC_NUM_IN, 2'b00};
         PC_LOAD_VALID_OUT <= 1'b1;
      end else begin
         PC_LOAD_VALID_OUT <= 1'b0;
      end
   end

   // Mode bits visible to the core
   always_ff @(posedge MCLK_IN) begin
      if (SRST_IN) begin
         MODE_BITS_OUT <= 7'h00;
      end else begin
         MODE_BITS_OUT <= mbits_q;
      end
   end

   // Assertions
   property p_page_reset;
      @(posedge MCLK_IN) SRST_IN |=> page_q == PAGE_RESET;
   endproperty
   a_page_reset: assert property (p_page_reset) else $error("page not cleared");

   property p_ptr_reset;
      @(posedge MCLK_IN) SRST_IN |=> vptr_q == VEC_PTR_RESET;
   endproperty
   a_ptr_reset: assert property (p_ptr_reset) else $error("pointer not all ones");

   property p_page_rd;
      @(posedge MCLK_IN) disable iff (SRST_IN)
         REG_RD_IN && REG_ADDR_IN == PAGE_REG_ADDR |=> REG_RDATA_OUT == {9'h000, $past(page_q)};
   endproperty
   a_page_rd: assert property (p_page_rd) else $error("page read wrong");

   property p_rom_prog;
      @(posedge MCLK_IN) disable iff (SRST_IN)
         ddec_a.tgt != MMD_TGT_ROM && ddec_b.tgt != MMD_TGT_ROM;
   endproperty
   a_rom_prog: assert property (p_rom_prog) else $error("ROM in data space");

   property p_lock;
      @(posedge MCLK_IN) disable iff (SRST_IN)
         sec_on && !FETCH_FROM_ROM_IN && pdec.tgt == MMD_TGT_ROM |=> ROM_READ_LOCK_OUT;
   endproperty
   a_lock: assert property (p_lock) else $error("ROM read not locked");

   property p_emu;
      @(posedge MCLK_IN) disable iff (SRST_IN) sec_on |=> !EMU_ENABLE_OUT && BSCAN_ENABLE_OUT;
   endproperty
   a_emu: assert property (p_emu) else $error("emulation left on");

   property p_boot_sec;
      @(posedge MCLK_IN) $fell(SRST_IN) && SEC_MODE_IN == MMD_SEC_RAMROM && !REG_WR_IN
         |=> !mbits_q[BOOT_BIT];
   endproperty
   a_boot_sec: assert property (p_boot_sec) else $error("boot bit not forced");

   property p_host;
      @(posedge MCLK_IN) disable iff (SRST_IN)
         SEC_MODE_IN == MMD_SEC_RAMROM && HOST_ADDR_IN < HOST_RD_LO |=> !HOST_RD_OK_OUT;
   endproperty
   a_host: assert property (p_host) else $error("host read outside window");

   property p_vec;
      @(posedge MCLK_IN) disable iff (SRST_IN)
         VEC_TAKE_IN |=> PC_LOAD_OUT[1:0] == 2'b00 && PC_LOAD_OUT[15:7] == $past(vptr_q);
   endproperty
   a_vec: assert property (p_vec) else $error("vector address wrong");

   property p_page0;
      @(posedge MCLK_IN) disable iff (SRST_IN)
         pext[15:0] <= DATA_PAGE0_TOP |-> pdec.tgt != MMD_TGT_DUAL_ACCESS_RAM;
   endproperty
   a_page0: assert property (p_page0) else $error("page 0 in program space");

   // Further checks on the register port, reset capture, decode, vector load and host window
   property p_rdata_idle;
      @(posedge MCLK_IN) disable iff (SRST_IN) !REG_RD_IN |=> REG_RDATA_OUT == 16'h0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data left standing");

   property p_mode_rd;
      @(posedge MCLK_IN) disable iff (SRST_IN)
         REG_RD_IN && REG_ADDR_IN == MODE_REG_ADDR |=> REG_RDATA_OUT == {$past(vptr_q), $past(mbits_q)};
   endproperty
   a_mode_rd: assert property (p_mode_rd) else $error("mode read wrong");

   property p_ptr_wr;
      @(posedge MCLK_IN) disable iff (SRST_IN)
         REG_WR_IN && REG_ADDR_IN == MODE_REG_ADDR |=> vptr_q == $past(REG_WDATA_IN[15:VEC_PTR_LSB]);
   endproperty
   a_ptr_wr: assert property (p_ptr_wr) else $error("pointer not loaded");

   property p_boot_pin;
      @(posedge MCLK_IN) $fell(SRST_IN) && SEC_MODE_IN != MMD_SEC_RAMROM && !REG_WR_IN
         |=> mbits_q[BOOT_BIT] == $past(boot_s2_q);
   endproperty
   a_boot_pin: assert property (p_boot_pin) else $error("boot bit not from pin");

   property p_vec_idle;
      @(posedge MCLK_IN) disable iff (SRST_IN) !VEC_TAKE_IN |=> !PC_LOAD_VALID_OUT;
   endproperty
   a_vec_idle: assert property (p_vec_idle) else $error("vector load without request");

   property p_ram_to_data_bit_off;
      @(posedge MCLK_IN) disable iff (SRST_IN)
         !mbits_q[RDATA_BIT] && DADDR_A_IN[15] |-> ddec_a.tgt == MMD_TGT_EXT;
   endproperty
   a_ram_to_data_bit_off: assert property (p_ram_to_data_bit_off) else $error("upper data not external");

   property p_host_hi;
      @(posedge MCLK_IN) disable iff (SRST_IN)
         SEC_MODE_IN == MMD_SEC_RAMROM && HOST_ADDR_IN > HOST_RD_HI |=> !HOST_RD_OK_OUT;
   endproperty
   a_host_hi: assert property (p_host_hi) else $error("host read above window");

   // Main scenarios
   c_overlay: cover property (@(posedge MCLK_IN) pdec.tgt == MMD_TGT_DUAL_ACCESS_RAM && !pext[16]);
   c_single_access_ram: cover property (@(posedge MCLK_IN) pdec.tgt == MMD_TGT_SINGLE_ACCESS_RAM);
   c_lock: cover property (@(posedge MCLK_IN) ROM_READ_LOCK_OUT);
   c_vec: cover property (@(posedge MCLK_IN) VEC_TAKE_IN);
   c_rd_wr: cover property (@(posedge MCLK_IN) ddec_a.tgt == MMD_TGT_DUAL_ACCESS_RAM && ddec_b.tgt == MMD_TGT_DUAL_ACCESS_RAM
                            && ddec_a.blk == ddec_b.blk && DWR_B_IN);

endmodule : mmd_decoder

`default_nettype wire

// ### design/mmd_pkg.sv
package mmd_pkg;

   // Register map of the plain register port
   localparam logic [15:0] PAGE_REG_ADDR = 16'h001E;
   localparam logic [15:0] MODE_REG_ADDR = 16'h001D;

   // Reset values
   localparam logic [6:0] PAGE_RESET = 7'h00;
   localparam logic [8:0] VEC_PTR_RESET = 9'h1FF;

   // Mode register bit positions
   localparam int VEC_PTR_LSB = 7;
   localparam int BOOT_BIT = 6;
   localparam int RAM_OVERLAY_BIT_BIT = 5;
   localparam int ADDRESS_VISIBILITY_BIT_BIT = 4;
   localparam int RDATA_BIT = 3;
   localparam int CLOCK_OUTPUT_OFF_BIT_BIT = 2;
   localparam int MULTIPLY_SATURATE_BIT_BIT = 1;
   localparam int SST_BIT = 0;

   // Decode boundaries
   localparam logic [15:0] ROM_BASE = 16'hC000;
   localparam logic [15:0] DATA_PAGE0_TOP = 16'h007F;
   localparam logic [15:0] DUAL_ACCESS_RAM_LO_TOP = 16'h7FFF;
   localparam logic [15:0] HOST_RD_LO = 16'h4000;
   localparam logic [15:0] HOST_RD_HI = 16'h5FFF;
   localparam logic [15:0] BOOT_VECTOR = 16'hFF80;
   localparam logic [15:0] ROM_LOCKED_DATA = 16'hFFFF;
   localparam logic [6:0] PAGE_DUAL_ACCESS_RAM_HI = 7'h01;
   localparam logic [6:0] PAGE_SINGLE_ACCESS_RAM_A = 7'h02;
   localparam logic [6:0] PAGE_SINGLE_ACCESS_RAM_B = 7'h03;

   // Security option selection
   typedef enum logic [1:0] {
      MMD_SEC_NONE,
      MMD_SEC_RAMROM,
      MMD_SEC_ROMONLY
   } mmd_sec_e;

   // Memory target of one access
   typedef enum logic [2:0] {
      MMD_TGT_EXT,
      MMD_TGT_ROM,
      MMD_TGT_DUAL_ACCESS_RAM,
      MMD_TGT_SINGLE_ACCESS_RAM,
      MMD_TGT_MMR
   } mmd_tgt_e;

   // Decoded access: target and block number
   typedef struct packed {
      mmd_tgt_e tgt;
      logic [2:0] blk;
   } mmd_dec_s;

endpackage : mmd_pkg

// ### verif/mmd_core_model.sv
`timescale 1ns/1ns
`default_nettype none

// Core side: program fetch and two data address buses
module mmd_core_model (
   input wire logic clk_in,
   output logic [15:0] paddr_out,
   output logic [15:0] daddr_a_out,
   output logic [15:0] daddr_b_out,
   output logic rom_fetch_out
);
   initial begin
      paddr_out = 16'h0000;
      daddr_a_out = 16'h0000;
      daddr_b_out = 16'h0000;
      rom_fetch_out = 1'b0;
   end

   // Drive one bus cycle just after an edge; the factory test area is never fetched
   task automatic issue(input logic [15:0] p, a, b, input logic rom);
      @(posedge clk_in);
      paddr_out <= (p >= 16'hFF00 && p <= 16'hFF7F) ? 16'hFF80 : p;
      daddr_a_out <= a;
      daddr_b_out <= b;
      rom_fetch_out <= rom;
   endtask : issue
endmodule : mmd_core_model

`default_nettype wire

// ### verif/mmd_decoder_bench.sv
`timescale 1ns/1ns
`default_nettype none

module mmd_decoder_bench;
   import mmd_pkg::*;
   logic MCLK_IN = 1'b0, SRST_IN = 1'b1, BOOT_PIN_IN = 1'b1, REG_WR_IN = 1'b0, REG_RD_IN = 1'b0;
   logic VEC_TAKE_IN = 1'b0, HOST_RD_IN = 1'b0, DWR_B_IN = 1'b0;
   mmd_sec_e SEC_MODE_IN = MMD_SEC_NONE;
   logic [15:0] REG_ADDR_IN = 16'h0000, REG_WDATA_IN = 16'h0000, HOST_ADDR_IN = 16'h0000;
   logic [15:0] REG_RDATA_OUT, PADDR_IN, DADDR_A_IN, DADDR_B_IN, LOCKED_DATA_OUT, PC_LOAD_OUT;
   logic [4:0] VEC_NUM_IN = 5'h00;
   logic [22:0] PADDR_EXT_OUT;
   logic [6:0] MODE_BITS_OUT;
   logic FETCH_FROM_ROM_IN, DUAL_CONFLICT_OUT, ROM_READ_LOCK_OUT, PC_LOAD_VALID_OUT;
   logic EMU_ENABLE_OUT, BSCAN_ENABLE_OUT, HOST_RD_OK_OUT;
   mmd_dec_s PDEC_OUT, DDEC_A_OUT, DDEC_B_OUT;
   int bad_count = 0;
   int checks = 0;

   // Clock at 10 MHz
   always #50 MCLK_IN = ~MCLK_IN;

   mmd_core_model core (.clk_in(MCLK_IN), .paddr_out(PADDR_IN), .daddr_a_out(DADDR_A_IN),
      .daddr_b_out(DADDR_B_IN), .rom_fetch_out(FETCH_FROM_ROM_IN));

   mmd_decoder dut (.MCLK_IN(MCLK_IN), .SRST_IN(SRST_IN), .BOOT_PIN_IN(BOOT_PIN_IN),
      .SEC_MODE_IN(SEC_MODE_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
      .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
      .PADDR_IN(PADDR_IN), .FETCH_FROM_ROM_IN(FETCH_FROM_ROM_IN), .DADDR_A_IN(DADDR_A_IN),
      .DADDR_B_IN(DADDR_B_IN), .DWR_B_IN(DWR_B_IN), .VEC_NUM_IN(VEC_NUM_IN), .VEC_TAKE_IN(VEC_TAKE_IN),
      .HOST_ADDR_IN(HOST_ADDR_IN), .HOST_RD_IN(HOST_RD_IN), .PDEC_OUT(PDEC_OUT),
      .PADDR_EXT_OUT(PADDR_EXT_OUT), .DDEC_A_OUT(DDEC_A_OUT), .DDEC_B_OUT(DDEC_B_OUT),
      .DUAL_CONFLICT_OUT(DUAL_CONFLICT_OUT), .ROM_READ_LOCK_OUT(ROM_READ_LOCK_OUT),
      .LOCKED_DATA_OUT(LOCKED_DATA_OUT), .PC_LOAD_OUT(PC_LOAD_OUT),
      .PC_LOAD_VALID_OUT(PC_LOAD_VALID_OUT), .EMU_ENABLE_OUT(EMU_ENABLE_OUT),
      .BSCAN_ENABLE_OUT(BSCAN_ENABLE_OUT), .HOST_RD_OK_OUT(HOST_RD_OK_OUT),
      .MODE_BITS_OUT(MODE_BITS_OUT));

   // Compare and count
   task automatic chk(input logic [22:0] got, exp, input string what);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // Verdict
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : finish_test

   // Reset with a chosen option and boot pin level
   task automatic do_reset(input mmd_sec_e sec, input logic pin);
      @(posedge MCLK_IN);
      SRST_IN <= 1'b1;
      SEC_MODE_IN <= sec;
      BOOT_PIN_IN <= pin;
      repeat (4) @(posedge MCLK_IN);
      SRST_IN <= 1'b0;
   endtask : do_reset

   // Register port write
   task automatic wr(input logic [15:0] a, d);
      @(posedge MCLK_IN);
      REG_ADDR_IN <= a;
      REG_WDATA_IN <= d;
      REG_WR_IN <= 1'b1;
      @(posedge MCLK_IN);
      REG_WR_IN <= 1'b0;
   endtask : wr

   // Register port read, data one cycle later
   task automatic rd(input logic [15:0] a, exp);
      @(posedge MCLK_IN);
      REG_ADDR_IN <= a;
      REG_RD_IN <= 1'b1;
      @(posedge MCLK_IN);
      REG_RD_IN <= 1'b0;
      #1 chk(REG_RDATA_OUT, exp, "read data");
   endtask : rd

   // Take a vector and check the loaded program counter
   task automatic vec(input logic [4:0] n, input logic [15:0] exp);
      @(posedge MCLK_IN);
      VEC_NUM_IN <= n;
      VEC_TAKE_IN <= 1'b1;
      @(posedge MCLK_IN);
      VEC_TAKE_IN <= 1'b0;
      #1 chk(PC_LOAD_OUT, exp, "vector");
      chk(PC_LOAD_VALID_OUT, 1'b1, "vector valid");
   endtask : vec

   // Host read grant
   task automatic host(input logic [15:0] a, input logic ok);
      @(posedge MCLK_IN);
      HOST_ADDR_IN <= a;
      HOST_RD_IN <= 1'b1;
      @(posedge MCLK_IN);
      HOST_RD_IN <= 1'b0;
      #1 chk(HOST_RD_OK_OUT, ok, "host grant");
   endtask : host

   // One decode cycle: program and port A targets
   task automatic dec(input logic [15:0] p, a, input logic rom, input mmd_dec_s ep, ea);
      core.issue(p, a, 16'h0010, rom);
      @(posedge MCLK_IN);
      #1 chk(PDEC_OUT, ep, "program decode");
      chk(DDEC_A_OUT, ea, "data decode");
   endtask : dec

   // Watchdog
   initial begin
      #2000000;
      bad_count++;
      finish_test();
   end

   // Test sequence
   initial begin
      repeat (2) @(posedge MCLK_IN);
      SRST_IN <= 1'b0;
      do_reset(MMD_SEC_NONE, 1'b1);
      rd(PAGE_REG_ADDR, 16'h0000);
      rd(MODE_REG_ADDR, 16'hFFC0);
      chk(MODE_BITS_OUT, 7'h40, "mode bits");
      chk(PC_LOAD_OUT, 16'hFF80, "reset vector");
      chk(PC_LOAD_VALID_OUT, 1'b0, "vector valid idle");
      chk(EMU_ENABLE_OUT, 1'b1, "emulation");
      rd(16'h0030, 16'h0000);
      vec(5'h03, 16'hFF8C);
      wr(MODE_REG_ADDR, 16'hFFA8);
      @(posedge MCLK_IN);
      #1 chk(MODE_BITS_OUT, 7'h28, "mode bits");
      wr(PAGE_REG_ADDR, 16'h0000);
      dec(16'hC000, 16'h2000, 1'b1, {MMD_TGT_ROM, 3'h0}, {MMD_TGT_DUAL_ACCESS_RAM, 3'h1});
      chk(DDEC_B_OUT, {MMD_TGT_MMR, 3'h0}, "data decode B");
      chk(DUAL_CONFLICT_OUT, 1'b0, "block clash");
      dec(16'h0040, 16'hC000, 1'b1, {MMD_TGT_EXT, 3'h0}, {MMD_TGT_DUAL_ACCESS_RAM, 3'h6});
      dec(16'h2000, 16'h8000, 1'b1, {MMD_TGT_DUAL_ACCESS_RAM, 3'h1}, {MMD_TGT_DUAL_ACCESS_RAM, 3'h4});
      chk(DUAL_CONFLICT_OUT, 1'b0, "block clash");
      @(posedge MCLK_IN);
      DWR_B_IN <= 1'b1;
      core.issue(16'h2000, 16'h2100, 16'h3000, 1'b1);
      @(posedge MCLK_IN);
      #1 chk(DUAL_CONFLICT_OUT, 1'b1, "block clash");
      chk(DDEC_B_OUT, {MMD_TGT_DUAL_ACCESS_RAM, 3'h1}, "data decode B");
      wr(PAGE_REG_ADDR, 16'h0001);
      dec(16'h8000, 16'h0100, 1'b1, {MMD_TGT_DUAL_ACCESS_RAM, 3'h4}, {MMD_TGT_DUAL_ACCESS_RAM, 3'h0});
      chk(PADDR_EXT_OUT, 23'h018000, "extended address");
      wr(PAGE_REG_ADDR, 16'h0002);
      dec(16'hA000, 16'h0100, 1'b1, {MMD_TGT_SINGLE_ACCESS_RAM, 3'h1}, {MMD_TGT_DUAL_ACCESS_RAM, 3'h0});
      chk(DUAL_CONFLICT_OUT, 1'b0, "block clash");
      wr(PAGE_REG_ADDR, 16'h0003);
      dec(16'hE000, 16'h0100, 1'b1, {MMD_TGT_SINGLE_ACCESS_RAM, 3'h7}, {MMD_TGT_DUAL_ACCESS_RAM, 3'h0});
      wr(PAGE_REG_ADDR, 16'h007F);
      rd(PAGE_REG_ADDR, 16'h007F);
      dec(16'h1234, 16'h0100, 1'b1, {MMD_TGT_DUAL_ACCESS_RAM, 3'h0}, {MMD_TGT_DUAL_ACCESS_RAM, 3'h0});
      chk(PADDR_EXT_OUT, 23'h7F1234, "extended address");
      wr(PAGE_REG_ADDR, 16'h0000);
      wr(MODE_REG_ADDR, 16'h0840);
      vec(5'h1F, 16'h087C);
      dec(16'hC000, 16'h8000, 1'b1, {MMD_TGT_EXT, 3'h6}, {MMD_TGT_EXT, 3'h4});
      dec(16'h2000, 16'hFFFF, 1'b1, {MMD_TGT_EXT, 3'h1}, {MMD_TGT_EXT, 3'h7});
      do_reset(MMD_SEC_RAMROM, 1'b1);
      rd(MODE_REG_ADDR, 16'hFF80);
      chk(EMU_ENABLE_OUT, 1'b0, "emulation");
      chk(BSCAN_ENABLE_OUT, 1'b1, "boundary scan");
      host(16'h4000, 1'b1);
      host(16'h5FFF, 1'b1);
      host(16'h6000, 1'b0);
      host(16'h3FFF, 1'b0);
      dec(16'hC000, 16'h0100, 1'b0, {MMD_TGT_ROM, 3'h0}, {MMD_TGT_DUAL_ACCESS_RAM, 3'h0});
      chk(ROM_READ_LOCK_OUT, 1'b1, "rom lock");
      chk(LOCKED_DATA_OUT, 16'hFFFF, "locked data");
      dec(16'hC000, 16'h0100, 1'b1, {MMD_TGT_ROM, 3'h0}, {MMD_TGT_DUAL_ACCESS_RAM, 3'h0});
      chk(ROM_READ_LOCK_OUT, 1'b0, "rom lock");
      wr(MODE_REG_ADDR, 16'hFFC0);
      rd(MODE_REG_ADDR, 16'hFFC0);
      do_reset(MMD_SEC_ROMONLY, 1'b1);
      rd(MODE_REG_ADDR, 16'hFFC0);
      host(16'h6000, 1'b1);
      chk(EMU_ENABLE_OUT, 1'b0, "emulation");
      do_reset(MMD_SEC_NONE, 1'b0);
      rd(MODE_REG_ADDR, 16'hFF80);
      chk(PC_LOAD_OUT, 16'hFF80, "reset vector");
      chk(EMU_ENABLE_OUT, 1'b1, "emulation");
      dec(16'hFF80, 16'h0100, 1'b1, {MMD_TGT_ROM, 3'h0}, {MMD_TGT_DUAL_ACCESS_RAM, 3'h0});
      finish_test();
   end
endmodule : mmd_decoder_bench

`default_nettype wire
